// ### adc_out_pkg.sv
// Constants for the dual converter output control block.
// Assumes a single sampling clock and synchronous reset.
package adc_out_pkg;
  localparam int SAMPLE_W = 12;
  localparam int LATENCY_CYC = 7;
  localparam logic [11:0] MID_SCALE_OB = 12'h800;
  localparam logic [11:0] MID_SCALE_TC = 12'h000;
  localparam int RECOVERY_US = 500;
  localparam int CLK_MHZ = 20;
  localparam int RECOVERY_CYC = RECOVERY_US * CLK_MHZ;
  localparam int SETTLE_CYC = 4;
  // Select input decoded levels
  localparam logic [1:0] SEL_SUPPLY = 2'h3;
  localparam logic [1:0] SEL_GROUND = 2'h0;
  localparam logic [1:0] SEL_REFMID = 2'h1;
  localparam logic [1:0] SEL_FLOAT = 2'h2;
  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_DOWN = 3'h2,
    ST_RECOVER = 3'h4
  } pwr_state_t;
endpackage

// ### dual_adc_output_control.sv
// Output control of a dual 12-bit pipelined converter.
// Assumes converter cores deliver one raw offset-binary word per channel per clock.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Disable input high tri-states that channel's data pins; low drives them. Shared mode ignores B's disable; A's also covers the indicator pin.
// - Both channels keep converting whatever the output disable levels are.
// - Power-down high holds the block in low power, no valid conversions.
// - In power-down outputs are undefined and pipeline contents are lost.
// - Select at supply: offset binary, stabiliser on.
// - Select at ground: two's complement, stabiliser on.
// - Select at reference mid node: two's complement, stabiliser bypassed.
// - Select floating: offset binary, stabiliser bypassed.
// - Select may change live; words wrong for a few cycles afterwards.
// - Bus mode low: each channel on its own output bus.
// - Bus mode high: both channels time-multiplexed on channel A pins.
// - Shared mode: indicator bit high with channel A data, low with B.
// - Stabiliser regenerates a stable clock from 20 to 80 percent duty.
// - Valid words only while channel disable and power-down are low; shared mode ignores channel B's disable.
// - Two's complement is offset binary with its top bit inverted.
module dual_adc_output_control #(
  parameter int SAMPLE_W = adc_out_pkg::SAMPLE_W,
  parameter int LATENCY_CYC = adc_out_pkg::LATENCY_CYC,
  parameter int RECOVERY_CYC = adc_out_pkg::RECOVERY_CYC
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Raw conversion words from the cores
  input wire logic [SAMPLE_W-1:0] chan_a_sample_in,
  input wire logic [SAMPLE_W-1:0] chan_b_sample_in,
  // Control pins
  input wire logic chan_a_output_disable_n_in,
  input wire logic chan_b_output_disable_n_in,
  input wire logic power_down_in,
  input wire logic [1:0] format_stabiliser_select_in,
  input wire logic bus_mode_in,
  // Receiver back-pressure
  input wire logic rx_ready_in,
  // Data pins, enable low while driving
  output logic [SAMPLE_W-1:0] chan_a_out_bits_out,
  output logic [SAMPLE_W-1:0] chan_a_out_bits_oe_n_out,
  output logic [SAMPLE_W-1:0] chan_b_out_bits_out,
  output logic [SAMPLE_W-1:0] chan_b_out_bits_oe_n_out,
  output logic out_valid_out,
  // Status
  output logic stabiliser_on_out,
  output logic results_settled_out,
  output logic low_power_out
);
  localparam int RCW = $clog2(RECOVERY_CYC + 1);
  localparam logic [RCW-1:0] REC_LOAD = RCW'(RECOVERY_CYC);

  // Synchronised control pins, reset to disabled, running, separate buses
  logic [3:0] ctl_s1_q, ctl_s2_q;
  logic [1:0] sel_s1_q, sel_s2_q;
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      ctl_s1_q <= 4'hC;
      ctl_s2_q <= 4'hC;
      sel_s1_q <= adc_out_pkg::SEL_SUPPLY;
      sel_s2_q <= adc_out_pkg::SEL_SUPPLY;
    end else begin
      ctl_s1_q <= {chan_a_output_disable_n_in, chan_b_output_disable_n_in, power_down_in, bus_mode_in};
      ctl_s2_q <= ctl_s1_q;
      sel_s1_q <= format_stabiliser_select_in;
      sel_s2_q <= sel_s1_q;
    end
  end
  logic dis_a, dis_b, pwr_dn, mux_mode;
  assign dis_a = ctl_s2_q[3];
  assign dis_b = ctl_s2_q[2];
  assign pwr_dn = ctl_s2_q[1];
  assign mux_mode = ctl_s2_q[0];

  // Format and stabiliser decode
  logic twos_fmt, stab_on;
  always_comb begin
    case (sel_s2_q)
      adc_out_pkg::SEL_SUPPLY: begin twos_fmt = 1'b0; stab_on = 1'b1; end
      adc_out_pkg::SEL_GROUND: begin twos_fmt = 1'b1; stab_on = 1'b1; end
      adc_out_pkg::SEL_REFMID: begin twos_fmt = 1'b1; stab_on = 1'b0; end
      default: begin twos_fmt = 1'b0; stab_on = 1'b0; end
    endcase
  end
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) stabiliser_on_out <= 1'b1;
    else stabiliser_on_out <= stab_on;
  end

  // Power state
  adc_out_pkg::pwr_state_t state_q;
  logic [RCW-1:0] rec_cnt_q;
  logic [3:0] settle_q;
  logic [1:0] sel_prev_q;
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_q <= adc_out_pkg::ST_RUN;
      rec_cnt_q <= '0;
    end else begin
      case (state_q)
        adc_out_pkg::ST_RUN: if (pwr_dn) state_q <= adc_out_pkg::ST_DOWN;
        adc_out_pkg::ST_DOWN: if (!pwr_dn) begin
          state_q <= adc_out_pkg::ST_RECOVER;
          rec_cnt_q <= REC_LOAD;
        end
        adc_out_pkg::ST_RECOVER: begin
          if (pwr_dn) state_q <= adc_out_pkg::ST_DOWN;
          else if (rec_cnt_q == '0) state_q <= adc_out_pkg::ST_RUN;
          else rec_cnt_q <= rec_cnt_q - 1'b1;
        end
        default: state_q <= adc_out_pkg::ST_RUN;
      endcase
    end
  end
  // Settle window after a live select change
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      sel_prev_q <= adc_out_pkg::SEL_SUPPLY;
      settle_q <= '0;
    end else begin
      sel_prev_q <= sel_s2_q;
      if (sel_prev_q != sel_s2_q) settle_q <= 4'(adc_out_pkg::SETTLE_CYC);
      else if (settle_q != '0) settle_q <= settle_q - 1'b1;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      low_power_out <= 1'b0;
      results_settled_out <= 1'b1;
    end else begin
      low_power_out <= (state_q == adc_out_pkg::ST_DOWN);
      // First word in the new format already counts as unsettled
      results_settled_out <= (state_q == adc_out_pkg::ST_RUN) && !pwr_dn && (settle_q == '0)
        && (sel_prev_q == sel_s2_q);
    end
  end

  // Conversion pipeline, one launch per clock per channel
  logic [SAMPLE_W-1:0] pipe_a_q [LATENCY_CYC];
  logic [SAMPLE_W-1:0] pipe_b_q [LATENCY_CYC];
  logic [LATENCY_CYC-1:0] pipe_v_q;
  genvar gi;
  generate
    for (gi = 0; gi < LATENCY_CYC; gi++) begin : g_pipe
      if (gi == 0) begin : g_first
        always_ff @(posedge clk_sys_in) begin
          if (reset_in || pwr_dn) begin
            pipe_a_q[gi] <= '0;
            pipe_b_q[gi] <= '0;
            pipe_v_q[gi] <= 1'b0;
          end else begin
            pipe_a_q[gi] <= chan_a_sample_in;
            pipe_b_q[gi] <= chan_b_sample_in;
            pipe_v_q[gi] <= 1'b1;
          end
        end
      end else begin : g_next
        always_ff @(posedge clk_sys_in) begin
          if (reset_in || pwr_dn) begin
            pipe_a_q[gi] <= '0;
            pipe_b_q[gi] <= '0;
            pipe_v_q[gi] <= 1'b0;
          end else begin
            pipe_a_q[gi] <= pipe_a_q[gi-1];
            pipe_b_q[gi] <= pipe_b_q[gi-1];
            pipe_v_q[gi] <= pipe_v_q[gi-1];
          end
        end
      end
    end
  endgenerate

  // Two-entry buffer between pipeline and pins
  logic [2*SAMPLE_W-1:0] buf_q [2];
  logic [1:0] buf_cnt_q;
  logic buf_rd_q, buf_wr_q;
  logic in_valid, in_ready, out_pop, half_q;
  logic pin_gate, out_adv, show;
  assign in_valid = pipe_v_q[LATENCY_CYC-1];
  assign in_ready = (buf_cnt_q != 2'h2);
  // Pins readable and converter running
  assign pin_gate = !pwr_dn && !dis_a && (mux_mode || !dis_b);
  // Held word stays on the pins until the receiver takes it
  assign out_adv = !out_valid_out || rx_ready_in;
  assign show = (buf_cnt_q != 2'h0) && out_adv;
  // Shared mode needs two pin cycles per buffered pair
  assign out_pop = show && (!mux_mode || half_q);
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || pwr_dn) begin
      buf_cnt_q <= '0;
      buf_rd_q <= 1'b0;
      buf_wr_q <= 1'b0;
    end else begin
      if (in_valid && in_ready) begin
        buf_q[buf_wr_q] <= {pipe_a_q[LATENCY_CYC-1], pipe_b_q[LATENCY_CYC-1]};
        buf_wr_q <= ~buf_wr_q;
      end
      if (out_pop) buf_rd_q <= ~buf_rd_q;
      buf_cnt_q <= buf_cnt_q + 2'(in_valid && in_ready) - 2'(out_pop);
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || pwr_dn || !mux_mode) half_q <= 1'b0;
    else if (show) half_q <= ~half_q;
  end

  // Output formatting and drive
  logic [SAMPLE_W-1:0] word_a, word_b, fmt_a, fmt_b;
  assign word_a = buf_q[buf_rd_q][2*SAMPLE_W-1:SAMPLE_W];
  assign word_b = buf_q[buf_rd_q][SAMPLE_W-1:0];
  assign fmt_a = {word_a[SAMPLE_W-1] ^ twos_fmt, word_a[SAMPLE_W-2:0]};
  assign fmt_b = {word_b[SAMPLE_W-1] ^ twos_fmt, word_b[SAMPLE_W-2:0]};
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      chan_a_out_bits_out <= '0;
      chan_b_out_bits_out <= '0;
      chan_a_out_bits_oe_n_out <= '1;
      chan_b_out_bits_oe_n_out <= '1;
      out_valid_out <= 1'b0;
    end else begin
      chan_a_out_bits_oe_n_out <= {SAMPLE_W{dis_a}};
      chan_b_out_bits_oe_n_out <= mux_mode ? {{(SAMPLE_W-1){1'b1}}, dis_a} : {SAMPLE_W{dis_b}};
      if (!pin_gate) out_valid_out <= 1'b0;
      else if (out_adv) out_valid_out <= show;
      if (show) begin
        if (mux_mode) begin
          chan_a_out_bits_out <= half_q ? fmt_b : fmt_a;
          chan_b_out_bits_out <= {{(SAMPLE_W-1){1'b0}}, ~half_q};
        end else begin
          chan_a_out_bits_out <= fmt_a;
          chan_b_out_bits_out <= fmt_b;
        end
      end
    end
  end
endmodule

`default_nettype wire

// ### dual_adc_output_control_checker.sv
// Port assertions for the dual converter output control.
// Bound to every instance; one clock, sync reset.
`timescale 1ns/1ps
`default_nettype none
module adc_ctl_checker (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic chan_a_output_disable_n_in,
  input wire logic power_down_in,
  input wire logic [1:0] format_stabiliser_select_in,
  input wire logic bus_mode_in,
  input wire logic rx_ready_in,
  input wire logic [11:0] chan_a_out_bits_out,
  input wire logic [11:0] chan_a_out_bits_oe_n_out,
  input wire logic [11:0] chan_b_out_bits_out,
  input wire logic [11:0] chan_b_out_bits_oe_n_out,
  input wire logic out_valid_out,
  input wire logic stabiliser_on_out,
  input wire logic results_settled_out,
  input wire logic low_power_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  sequence s_sel_held; $stable(format_stabiliser_select_in)[*6]; endsequence
  sequence s_a_word;
    bus_mode_in && !power_down_in && out_valid_out && rx_ready_in && chan_b_out_bits_oe_n_out[11]
      && !chan_b_out_bits_oe_n_out[0] && chan_b_out_bits_out[0];
  endsequence
  property p_quiet; low_power_out |-> !out_valid_out; endproperty
  a_quiet: assert property (p_quiet) else $error("valid in power-down");
  property p_oe_off; chan_a_output_disable_n_in[*4] |-> &chan_a_out_bits_oe_n_out; endproperty
  a_oe_off: assert property (p_oe_off) else $error("pins not released");
  property p_oe_on;
    (!chan_a_output_disable_n_in && !power_down_in)[*4] |-> chan_a_out_bits_oe_n_out == 12'h000;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("pins not driven");
  property p_shared; bus_mode_in[*4] |-> &chan_b_out_bits_oe_n_out[11:1]; endproperty
  a_shared: assert property (p_shared) else $error("b bus driven in shared mode");
  property p_stab;
    s_sel_held |-> stabiliser_on_out == (format_stabiliser_select_in[0] == format_stabiliser_select_in[1]);
  endproperty
  a_stab: assert property (p_stab) else $error("stabiliser state");
  property p_recover; $fell(low_power_out) |-> (!results_settled_out)[*8]; endproperty
  a_recover: assert property (p_recover) else $error("settled too early");
  property p_mux; s_a_word |=> out_valid_out && !chan_b_out_bits_out[0]; endproperty
  a_mux: assert property (p_mux) else $error("b word not after a word");
  property p_stall;
    (!power_down_in)[*3] ##0 out_valid_out && !rx_ready_in |=> out_valid_out && $stable(chan_a_out_bits_out);
  endproperty
  a_stall: assert property (p_stall) else $error("word lost in stall");
endmodule
bind dual_adc_output_control adc_ctl_checker u_chk (.*);
`default_nettype wire

// ### rx_capture_model.sv
// Receiving logic: captures words, can stall.
// Same clock as the block.
`timescale 1ns/1ps
`default_nettype none
module rx_capture_model (
  input wire logic clk_in,
  input wire logic hold_in,
  input wire logic settled_in,
  input wire logic valid_in,
  input wire logic [11:0] a_in,
  input wire logic [11:0] b_in,
  output logic ready_out
);
  logic [11:0] qa[$];
  logic [11:0] qb[$];
  assign ready_out = !hold_in;
  always @(posedge clk_in) begin
    if (valid_in && ready_out && settled_in) begin
      qa.push_back(a_in);
      qb.push_back(b_in);
    end
  end
endmodule
`default_nettype wire

// ### dual_adc_output_control_tb_top.sv
// Bench for the dual converter output control.
// Inputs change 5 ns after each rising edge.
`timescale 1ns/1ps
`default_nettype none
module dual_adc_output_control_tb_top;
  logic clk = 0, rst = 1, dis_a = 0, dis_b = 0, pwr_dn = 0, mux = 0, hold = 0;
  logic [1:0] sel = adc_out_pkg::SEL_SUPPLY;
  logic [11:0] sa = adc_out_pkg::MID_SCALE_OB, sb = 12'hABC, oa, ob, oe_a, oe_b;
  logic vld, rdy, stab, setl, lp;
  int n_errors = 0, comparisons = 0, cyc = 0;
  initial forever #25 clk = ~clk;
  dual_adc_output_control #(.RECOVERY_CYC(20)) dut (.clk_sys_in(clk), .reset_in(rst),
    .chan_a_sample_in(sa), .chan_b_sample_in(sb), .chan_a_output_disable_n_in(dis_a),
    .chan_b_output_disable_n_in(dis_b), .power_down_in(pwr_dn), .format_stabiliser_select_in(sel),
    .bus_mode_in(mux), .rx_ready_in(rdy), .chan_a_out_bits_out(oa), .chan_a_out_bits_oe_n_out(oe_a),
    .chan_b_out_bits_out(ob), .chan_b_out_bits_oe_n_out(oe_b), .out_valid_out(vld),
    .stabiliser_on_out(stab), .results_settled_out(setl), .low_power_out(lp));
  rx_capture_model rx (.clk_in(clk), .hold_in(hold), .settled_in(setl), .valid_in(vld),
    .a_in(oa), .b_in(ob), .ready_out(rdy));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      end_of_test();
    end
  end
  initial begin
    step(6);
    rst = 0;
    for (int i = 0; i < 4; i++) begin
      sel = 2'(i);
      step(20);
      chk(rx.qa[$], sa ^ {i < 2, 11'h000});
      chk(rx.qb[$], sb ^ {i < 2, 11'h000});
      chk({11'h000, stab}, {11'h000, i[0] == i[1]});
    end
    hold = 1;
    sa = 12'h5A5;
    step(10);
    chk({11'h000, vld}, 12'h001);
    hold = 0;
    step(20);
    chk(rx.qa[$], 12'h5A5);
    dis_a = 1;
    dis_b = 1;
    sa = 12'h321;
    step(12);
    chk(oe_a, 12'hFFF);
    chk(oe_b, 12'hFFF);
    dis_a = 0;
    dis_b = 0;
    step(4);
    chk(oa, 12'h321);
    chk(oe_a, 12'h000);
    dis_b = 1;
    step(4);
    chk(oe_a, 12'h000);
    chk(oe_b, 12'hFFF);
    chk({11'h000, vld}, 12'h000);
    mux = 1;
    sa = 12'h111;
    sb = 12'h222;
    step(20);
    chk(oe_b, 12'hFFE);
    chk(rx.qa[$ - !rx.qb[$][0]], 12'h111);
    chk(rx.qa[$ - rx.qb[$][0]], 12'h222);
    mux = 0;
    dis_b = 0;
    pwr_dn = 1;
    step(10);
    chk({10'h000, lp, vld}, 12'h002);
    pwr_dn = 0;
    step(6);
    chk({11'h000, setl}, 12'h000);
    chk({11'h000, vld}, 12'h000);
    step(30);
    chk({11'h000, setl}, 12'h001);
    step(20);
    chk(rx.qb[$], 12'h222);
    end_of_test();
  end
endmodule
`default_nettype wire
